// File: rtl/dcvb_bank.sv
// Configuration variable bank with speed ramp and decoded settings
// Functional notes
// - Startup delay one steps speed every 5ms
// - Format enables: DC, DCC, trinary, third
// - Analog mode F1-F8 from low function byte
// - Access only when lock key equals index, except the lock key itself
// - Long address high and low bytes, 2000
// - Consist zero disables; bit 7 reverses direction
// - Asymmetric stop enables per rail polarity
// - Bit 7 picks forward or reverse asymmetric
// - Feedback channels and auto registration enables
// - Direction invert; 28 or 14 speed steps
// - Auto analog switching, else digital only
// - Feedback enable; speed table selection
// - Bit 5 selects long or short address
// - Fault memory: output, motor, overtemperature
// - Firmware version is read only
// - Writing reset variable restores factory settings
// - Value 1 base bank; 2-4 extended banks
`timescale 1ns/1ps
`default_nettype none
`include "dcvb_consts.svh"

module dcvb_bank
  import dcvb_pkg::*;
#(
  parameter int TICK_CYCLES = `DCVB_TICK_CYCLES,
  parameter logic [7:0] FW_VERSION = 8'h17,
  parameter logic [7:0] MAKER_ID = 8'h5A // Arbitrary value
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic cv_wr,
  input wire logic cv_rd,
  input wire logic [9:0] cv_num,
  input wire logic [7:0] cv_wdata,
  output logic cv_ack,
  output logic cv_refused,
  output logic [7:0] cv_rdata,
  output logic [1:0] bank_restore,
  output logic bank_restore_stb,
  input wire logic [7:0] target_speed,
  output logic [7:0] current_speed,
  input wire logic analog_detect,
  input wire logic [12:0] digital_func,
  output logic [12:0] function_output,
  output logic analog_run,
  output logic [3:0] format_enables,
  output logic [13:0] active_address,
  output logic long_addr_sel,
  input wire logic dir_request,
  input wire logic consist_sel,
  output logic consist_active,
  output logic direction_reverse,
  output logic asymmetric_stop_detect,
  input wire logic dc_brake_section,
  input wire logic dc_section_reverse,
  output logic dc_brake_stop,
  output logic [2:0] feedback_enables,
  output logic speed_steps_28,
  output logic speed_table_sel,
  input wire logic [2:0] fault_event,
  output logic [2:0] fault_flags
);

  function automatic dcvb_byte_t factory_val(input logic [4:0] sel);
    case (sel)
      `DCVB_CV_SHORT_ADDR: factory_val = `DCVB_RST_SHORT_ADDR;
      `DCVB_CV_MIN_SPEED: factory_val = `DCVB_RST_MIN_SPEED;
      `DCVB_CV_STARTUP_DLY: factory_val = `DCVB_RST_STARTUP_DLY;
      `DCVB_CV_BRAKING_DLY: factory_val = `DCVB_RST_BRAKING_DLY;
      `DCVB_CV_MAX_SPEED: factory_val = `DCVB_RST_MAX_SPEED;
      `DCVB_CV_MID_SPEED: factory_val = `DCVB_RST_MID_SPEED;
      `DCVB_CV_FORMATS: factory_val = `DCVB_RST_FORMATS;
      `DCVB_CV_ANA_FN_LOW: factory_val = `DCVB_RST_ANA_FN_LOW;
      `DCVB_CV_ANA_FN_HIGH: factory_val = `DCVB_RST_ANA_FN_HIGH;
      `DCVB_CV_LOCK_KEY: factory_val = `DCVB_RST_LOCK_KEY;
      `DCVB_CV_LOCK_INDEX: factory_val = `DCVB_RST_LOCK_INDEX;
      `DCVB_CV_LONG_HIGH: factory_val = `DCVB_RST_LONG_HIGH;
      `DCVB_CV_LONG_LOW: factory_val = `DCVB_RST_LONG_LOW;
      `DCVB_CV_CONSIST: factory_val = `DCVB_RST_CONSIST;
      `DCVB_CV_BRAKE_SIG: factory_val = `DCVB_RST_BRAKE_SIG;
      `DCVB_CV_FEEDBACK: factory_val = `DCVB_RST_FEEDBACK;
      `DCVB_CV_STD_CFG: factory_val = `DCVB_RST_STD_CFG;
      default: factory_val = 8'h00;
    endcase
  endfunction

  localparam int CW = $clog2(TICK_CYCLES + 1);
  localparam logic [CW-1:0] TICK_LAST = CW'(TICK_CYCLES - 1);
  localparam logic [31:0] MAP = `DCVB_MAP_MASK;
  localparam logic [31:0] WRITABLE = `DCVB_WRITABLE_MASK;

  dcvb_byte_t cv_r [0:31];
  logic ack_r, refused_r, restore_stb_r;
  logic [7:0] rdata_r, speed_r, ramp_cnt_r;
  logic [1:0] restore_r;
  logic [CW-1:0] base_cnt_r;
  logic [12:0] func_r;
  logic analog_r, long_r, consist_r, dir_r, asym_r, dcstop_r;
  logic steps_r, table_r;
  logic [3:0] fmt_r;
  logic [13:0] addr_r;
  logic [2:0] fb_r;

  // Decode of a programming access
  wire access = cv_wr | cv_rd;
  wire [4:0] idx = cv_num[4:0];
  wire in_map = (cv_num[9:5] == 5'h00) & MAP[idx];
  wire is_key = in_map & (idx == `DCVB_CV_LOCK_KEY);
  // Key stays reachable so a mismatched decoder can be selected again
  wire lock_open = cv_r[`DCVB_CV_LOCK_KEY] == cv_r[`DCVB_CV_LOCK_INDEX];
  wire allowed = lock_open | is_key;
  wire wr_ok = cv_wr & allowed & in_map;
  wire restore_wr = wr_ok & (idx == `DCVB_CV_FACTORY_RST);
  wire restore_base = restore_wr & (cv_wdata == `DCVB_RESTORE_BASE);
  wire restore_bank = restore_wr & (cv_wdata >= `DCVB_RESTORE_BANK_LO) &
    (cv_wdata <= `DCVB_RESTORE_BANK_HI);
  wire [1:0] bank_code = 2'(cv_wdata - `DCVB_RESTORE_BANK_LO);
  wire [7:0] rd_mux = !in_map ? 8'h00 :
    (idx == `DCVB_CV_FW_VERSION) ? FW_VERSION :
    (idx == `DCVB_CV_FACTORY_RST) ? MAKER_ID : cv_r[idx];

  // One storage byte per variable; absent variables stay constant zero
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++) begin : g_cv
      localparam logic [4:0] GI = 5'(gi);
      if (gi == 30) begin : g_fault
        // Fault events win over a clearing write in the same cycle
        wire [7:0] base = (wr_ok && idx == GI) ? {5'h00, cv_wdata[2:0]} :
          cv_r[gi];
        always_ff @(posedge clk) begin
          if (rst || restore_base) begin
            cv_r[gi] <= factory_val(GI);
          end else begin
            cv_r[gi] <= base | {5'h00, fault_event};
          end
        end
      end else if (WRITABLE[gi]) begin : g_rw
        always_ff @(posedge clk) begin
          if (rst || restore_base) begin
            cv_r[gi] <= factory_val(GI);
          end else if (wr_ok && idx == GI) begin
            cv_r[gi] <= cv_wdata;
          end
        end
      end else begin : g_none
        always_ff @(posedge clk) begin
          cv_r[gi] <= 8'h00;
        end
      end
    end
  endgenerate

  // Access answer, one cycle after the request
  always_ff @(posedge clk) begin
    if (rst) begin
      ack_r <= 1'b0;
      refused_r <= 1'b0;
      rdata_r <= 8'h00;
      restore_r <= 2'h0;
      restore_stb_r <= 1'b0;
    end else begin
      ack_r <= access;
      refused_r <= access & !allowed;
      rdata_r <= (cv_rd && !cv_wr && allowed) ? rd_mux : 8'h00;
      restore_stb_r <= restore_bank;
      restore_r <= restore_bank ? bank_code : restore_r;
    end
  end

  // Speed ramp on a 5 ms base tick, scaled by the delay variables
  wire tick = base_cnt_r == TICK_LAST;
  wire accel = target_speed > speed_r;
  wire brake = target_speed < speed_r;
  dcvb_ramp_t ramp;
  assign ramp = accel ? DCVB_ACCEL : (brake ? DCVB_BRAKE : DCVB_HOLD);
  wire [7:0] dly = (ramp == DCVB_ACCEL) ? cv_r[`DCVB_CV_STARTUP_DLY] :
    cv_r[`DCVB_CV_BRAKING_DLY];
  wire step = (ramp != DCVB_HOLD) &
    ((dly == 8'h00) | (tick & (ramp_cnt_r == dly - 8'h01)));
  logic [7:0] speed_nxt;
  always_comb begin
    unique case (ramp)
      DCVB_ACCEL: speed_nxt = step ? speed_r + 8'h01 : speed_r;
      DCVB_BRAKE: speed_nxt = step ? speed_r - 8'h01 : speed_r;
      DCVB_HOLD: speed_nxt = speed_r;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      base_cnt_r <= '0;
      ramp_cnt_r <= 8'h00;
      speed_r <= 8'h00;
    end else begin
      base_cnt_r <= tick ? '0 : base_cnt_r + CW'(1);
      if (ramp == DCVB_HOLD || step) begin
        ramp_cnt_r <= 8'h00;
      end else if (tick) begin
        ramp_cnt_r <= ramp_cnt_r + 8'h01;
      end
      speed_r <= speed_nxt;
    end
  end

  // Settings decoded into registered controls
  wire [7:0] fmt_cv = cv_r[`DCVB_CV_FORMATS];
  wire [7:0] cfg_cv = cv_r[`DCVB_CV_STD_CFG];
  wire [7:0] brk_cv = cv_r[`DCVB_CV_BRAKE_SIG];
  wire [7:0] fb_cv = cv_r[`DCVB_CV_FEEDBACK];
  wire [7:0] con_cv = cv_r[`DCVB_CV_CONSIST];
  wire [7:0] fn_lo = cv_r[`DCVB_CV_ANA_FN_LOW];
  wire [7:0] fn_hi = cv_r[`DCVB_CV_ANA_FN_HIGH];
  wire analog_nxt = analog_detect & cfg_cv[`DCVB_CFG_AUTO_ANALOG] &
    fmt_cv[`DCVB_FMT_DC];
  wire [12:0] func_nxt = analog_nxt ?
    {fn_hi[7:4], fn_lo, fn_hi[0]} : digital_func;
  wire [13:0] long_addr = {cv_r[`DCVB_CV_LONG_HIGH][5:0],
    cv_r[`DCVB_CV_LONG_LOW]};
  wire long_nxt = cfg_cv[`DCVB_CFG_LONG_ADDR];
  wire [13:0] addr_nxt = long_nxt ? long_addr :
    {6'h00, cv_r[`DCVB_CV_SHORT_ADDR]};
  wire consist_nxt = con_cv[6:0] != 7'h00;
  wire dir_nxt = dir_request ^ cfg_cv[`DCVB_CFG_INVERT] ^
    (consist_sel & consist_nxt & con_cv[`DCVB_CONSIST_REVERSE]);
  // Asymmetric stop only in the travel direction bit 7 selects
  wire asym_nxt = (brk_cv[`DCVB_BRK_RIGHT] | brk_cv[`DCVB_BRK_LEFT]) &
    (dir_nxt == brk_cv[`DCVB_BRK_REVERSE]);
  wire dcstop_nxt = brk_cv[`DCVB_BRK_DC_DIR] & dc_brake_section &
    (dc_section_reverse == dir_nxt);
  wire [2:0] fb_nxt = {fb_cv[`DCVB_FB_AUTO_REG],
    fb_cv[`DCVB_FB_CH2] & cfg_cv[`DCVB_CFG_FEEDBACK],
    fb_cv[`DCVB_FB_CH1] & cfg_cv[`DCVB_CFG_FEEDBACK]};

  always_ff @(posedge clk) begin
    if (rst) begin
      func_r <= 13'h0000;
      analog_r <= 1'b0;
      fmt_r <= 4'h0;
      addr_r <= 14'h0000;
      long_r <= 1'b0;
      consist_r <= 1'b0;
      dir_r <= 1'b0;
      asym_r <= 1'b0;
      dcstop_r <= 1'b0;
      fb_r <= 3'h0;
      steps_r <= 1'b0;
      table_r <= 1'b0;
    end else begin
      func_r <= func_nxt;
      analog_r <= analog_nxt;
      fmt_r <= {fmt_cv[`DCVB_FMT_THIRD], fmt_cv[`DCVB_FMT_TRINARY],
        fmt_cv[`DCVB_FMT_DCC], fmt_cv[`DCVB_FMT_DC]};
      addr_r <= addr_nxt;
      long_r <= long_nxt;
      consist_r <= consist_nxt;
      dir_r <= dir_nxt;
      asym_r <= asym_nxt;
      dcstop_r <= dcstop_nxt;
      fb_r <= fb_nxt;
      steps_r <= cfg_cv[`DCVB_CFG_STEPS28];
      table_r <= cfg_cv[`DCVB_CFG_TABLE];
    end
  end

  assign cv_ack = ack_r;
  assign cv_refused = refused_r;
  assign cv_rdata = rdata_r;
  assign bank_restore = restore_r;
  assign bank_restore_stb = restore_stb_r;
  assign current_speed = speed_r;
  assign function_output = func_r;
  assign analog_run = analog_r;
  assign format_enables = fmt_r;
  assign active_address = addr_r;
  assign long_addr_sel = long_r;
  assign consist_active = consist_r;
  assign direction_reverse = dir_r;
  assign asymmetric_stop_detect = asym_r;
  assign dc_brake_stop = dcstop_r;
  assign feedback_enables = fb_r;
  assign speed_steps_28 = steps_r;
  assign speed_table_sel = table_r;
  assign fault_flags = cv_r[`DCVB_CV_FAULT][2:0];

  property p_lock_refuse;
    @(posedge clk) disable iff (rst)
    access && !allowed |=> cv_ack && cv_refused;
  endproperty
  a_lock_refuse: assert property (p_lock_refuse)
    else $error("locked access not refused");

  property p_lock_nowrite;
    @(posedge clk) disable iff (rst)
    cv_wr && !lock_open && idx == `DCVB_CV_MAX_SPEED
      |=> $stable(cv_r[`DCVB_CV_MAX_SPEED]);
  endproperty
  a_lock_nowrite: assert property (p_lock_nowrite)
    else $error("locked write changed a variable");

  property p_fw_read;
    @(posedge clk) disable iff (rst)
    cv_rd && !cv_wr && allowed && cv_num == 10'h007 |=> cv_rdata == FW_VERSION;
  endproperty
  a_fw_read: assert property (p_fw_read)
    else $error("version read wrong");

  property p_accel_step;
    @(posedge clk) disable iff (rst)
    ramp == DCVB_ACCEL && step |=> speed_r == $past(speed_r) + 8'h01;
  endproperty
  a_accel_step: assert property (p_accel_step)
    else $error("speed did not rise by one");

  property p_ramp_hold;
    @(posedge clk) disable iff (rst)
    ramp == DCVB_ACCEL && dly != 8'h00 && !tick |=> speed_r == $past(speed_r);
  endproperty
  a_ramp_hold: assert property (p_ramp_hold)
    else $error("speed moved between ticks");

  property p_analog_fn;
    @(posedge clk) disable iff (rst)
    analog_nxt |=> function_output[8:1] == $past(fn_lo);
  endproperty
  a_analog_fn: assert property (p_analog_fn)
    else $error("analog function keys wrong");

  property p_fault_set;
    @(posedge clk) disable iff (rst)
    fault_event[1] && !restore_base |=> fault_flags[1];
  endproperty
  a_fault_set: assert property (p_fault_set)
    else $error("motor fault lost");

  property p_restore;
    @(posedge clk) disable iff (rst)
    restore_base |=> cv_r[`DCVB_CV_MAX_SPEED] == `DCVB_RST_MAX_SPEED ##1
      cv_r[`DCVB_CV_STD_CFG] == `DCVB_RST_STD_CFG || $past(wr_ok);
  endproperty
  a_restore: assert property (p_restore)
    else $error("factory restore incomplete");

  property p_long_addr;
    @(posedge clk) disable iff (rst)
    long_nxt |=> active_address == $past(long_addr);
  endproperty
  a_long_addr: assert property (p_long_addr)
    else $error("long address not selected");

  property p_consist_off;
    @(posedge clk) disable iff (rst)
    con_cv[6:0] == 7'h00 |=> !consist_active;
  endproperty
  a_consist_off: assert property (p_consist_off)
    else $error("consist active at zero");

  c_restore: cover property (@(posedge clk) disable iff (rst) restore_base);
  c_refused: cover property (@(posedge clk) disable iff (rst)
    access && !allowed);
  c_accel: cover property (@(posedge clk) disable iff (rst)
    ramp == DCVB_ACCEL && step && tick);

endmodule

`default_nettype wire

// File: inc/dcvb_consts.svh
// Offsets, factory values, field positions and timing of the variable bank
`ifndef DCVB_CONSTS_SVH
`define DCVB_CONSTS_SVH

`define DCVB_CV_SHORT_ADDR 5'h01
`define DCVB_CV_MIN_SPEED 5'h02
`define DCVB_CV_STARTUP_DLY 5'h03
`define DCVB_CV_BRAKING_DLY 5'h04
`define DCVB_CV_MAX_SPEED 5'h05
`define DCVB_CV_MID_SPEED 5'h06
`define DCVB_CV_FW_VERSION 5'h07
`define DCVB_CV_FACTORY_RST 5'h08
`define DCVB_CV_FORMATS 5'h0C
`define DCVB_CV_ANA_FN_LOW 5'h0D
`define DCVB_CV_ANA_FN_HIGH 5'h0E
`define DCVB_CV_LOCK_KEY 5'h0F
`define DCVB_CV_LOCK_INDEX 5'h10
`define DCVB_CV_LONG_HIGH 5'h11
`define DCVB_CV_LONG_LOW 5'h12
`define DCVB_CV_CONSIST 5'h13
`define DCVB_CV_BRAKE_SIG 5'h1B
`define DCVB_CV_FEEDBACK 5'h1C
`define DCVB_CV_STD_CFG 5'h1D
`define DCVB_CV_FAULT 5'h1E

`define DCVB_MAP_MASK 32'h780F_F1FE
`define DCVB_WRITABLE_MASK 32'h780F_F07E

`define DCVB_RST_SHORT_ADDR 8'h03
`define DCVB_RST_MIN_SPEED 8'h01
`define DCVB_RST_STARTUP_DLY 8'h05
`define DCVB_RST_BRAKING_DLY 8'h05
`define DCVB_RST_MAX_SPEED 8'h30
`define DCVB_RST_MID_SPEED 8'h18
`define DCVB_RST_FORMATS 8'hFF
`define DCVB_RST_ANA_FN_LOW 8'h00
`define DCVB_RST_ANA_FN_HIGH 8'h01
`define DCVB_RST_LOCK_KEY 8'h01
`define DCVB_RST_LOCK_INDEX 8'h01
`define DCVB_RST_LONG_HIGH 8'hC7
`define DCVB_RST_LONG_LOW 8'hD0
`define DCVB_RST_CONSIST 8'h00
`define DCVB_RST_BRAKE_SIG 8'h00
`define DCVB_RST_FEEDBACK 8'h83
`define DCVB_RST_STD_CFG 8'h0E
`define DCVB_RST_FAULT 8'h00

`define DCVB_RESTORE_BASE 8'h01
`define DCVB_RESTORE_BANK_LO 8'h02
`define DCVB_RESTORE_BANK_HI 8'h04

`define DCVB_FMT_DC 0
`define DCVB_FMT_DCC 2
`define DCVB_FMT_TRINARY 3
`define DCVB_FMT_THIRD 4
`define DCVB_BRK_RIGHT 0
`define DCVB_BRK_LEFT 1
`define DCVB_BRK_DC_DIR 5
`define DCVB_BRK_REVERSE 7
`define DCVB_FB_CH1 0
`define DCVB_FB_CH2 1
`define DCVB_FB_AUTO_REG 7
`define DCVB_CFG_INVERT 0
`define DCVB_CFG_STEPS28 1
`define DCVB_CFG_AUTO_ANALOG 2
`define DCVB_CFG_FEEDBACK 3
`define DCVB_CFG_TABLE 4
`define DCVB_CFG_LONG_ADDR 5
`define DCVB_CONSIST_REVERSE 7

`define DCVB_TICK_US 5000
`define DCVB_CLK_KHZ 50000
`define DCVB_TICK_CYCLES (`DCVB_TICK_US * `DCVB_CLK_KHZ / 1000)

`endif

// File: inc/dcvb_pkg.sv
// Types shared by the variable bank
`default_nettype none
package dcvb_pkg;
  typedef logic [7:0] dcvb_byte_t;
  typedef enum logic [1:0] {DCVB_HOLD, DCVB_ACCEL, DCVB_BRAKE} dcvb_ramp_t;
endpackage
`default_nettype wire

// File: bench/dcvb_station.sv
// Command station model driving the variable access port
`timescale 1ns/1ps
`default_nettype none
module dcvb_station (
  input wire logic clk,
  output logic cv_wr,
  output logic cv_rd,
  output logic [9:0] cv_num,
  output logic [7:0] cv_wdata,
  input wire logic cv_ack,
  input wire logic cv_refused,
  input wire logic [7:0] cv_rdata
);
  initial begin
    cv_wr = 1'b0;
    cv_rd = 1'b0;
    cv_num = 10'h000;
    cv_wdata = 8'h00;
  end
  // One request per call; the answer is read just after the taking edge
  task automatic xfer(input logic wr, input logic [9:0] num,
    input logic [7:0] data, output logic [9:0] ans);
    @(posedge clk);
    cv_wr <= wr;
    cv_rd <= ~wr;
    cv_num <= num;
    cv_wdata <= data;
    @(posedge clk);
    cv_wr <= 1'b0;
    cv_rd <= 1'b0;
    // Released lines must not look like a held request
    cv_num <= ~num;
    cv_wdata <= ~data;
    #1;
    ans = {cv_ack, cv_refused, cv_rdata};
  endtask
endmodule
`default_nettype wire

// File: bench/decoder_config_variable_bank_tb_top.sv
// Self-checking bench for the configuration variable bank
`timescale 1ns/1ps
`default_nettype none
module decoder_config_variable_bank_tb_top;
  localparam logic [7:0] FW = 8'h2C; // Arbitrary value
  localparam logic [7:0] MAKER = 8'h3B; // Arbitrary value
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cv_wr, cv_rd, cv_ack, cv_refused;
  logic [9:0] cv_num;
  logic [7:0] cv_wdata, cv_rdata, current_speed;
  logic [7:0] target_speed = 8'h00;
  logic [1:0] bank_restore;
  logic bank_restore_stb, analog_run, long_addr_sel, consist_active;
  logic direction_reverse, asymmetric_stop_detect, dc_brake_stop;
  logic speed_steps_28, speed_table_sel;
  logic analog_detect = 1'b0;
  logic dir_request = 1'b0;
  logic consist_sel = 1'b0;
  logic dc_brake_section = 1'b0;
  logic dc_section_reverse = 1'b0;
  logic [12:0] digital_func = 13'h0000;
  logic [12:0] function_output;
  logic [3:0] format_enables;
  logic [13:0] active_address;
  logic [2:0] feedback_enables, fault_flags;
  logic [2:0] fault_event = 3'h0;
  logic [9:0] ans;
  int mismatches = 0;
  int n_tests = 0;
  int cnt;
  logic [9:0] rn [20] = '{10'h001, 10'h002, 10'h003, 10'h004, 10'h005,
    10'h006, 10'h007, 10'h008, 10'h00C, 10'h00D, 10'h00E, 10'h00F, 10'h010,
    10'h011, 10'h012, 10'h013, 10'h01B, 10'h01C, 10'h01D, 10'h01E};
  logic [7:0] rv [20] = '{8'h03, 8'h01, 8'h05, 8'h05, 8'h30, 8'h18, FW,
    MAKER, 8'hFF, 8'h00, 8'h01, 8'h01, 8'h01, 8'hC7, 8'hD0, 8'h00, 8'h00,
    8'h83, 8'h0E, 8'h00};

  always #10 clk = ~clk;

  dcvb_station u_station (.clk(clk), .cv_wr(cv_wr), .cv_rd(cv_rd),
    .cv_num(cv_num), .cv_wdata(cv_wdata), .cv_ack(cv_ack),
    .cv_refused(cv_refused), .cv_rdata(cv_rdata));

  // Short tick count keeps the ramp test brief
  dcvb_bank #(.TICK_CYCLES(4), .FW_VERSION(FW), .MAKER_ID(MAKER)) u_dut (
    .clk(clk), .rst(rst), .cv_wr(cv_wr), .cv_rd(cv_rd), .cv_num(cv_num),
    .cv_wdata(cv_wdata), .cv_ack(cv_ack), .cv_refused(cv_refused),
    .cv_rdata(cv_rdata), .bank_restore(bank_restore),
    .bank_restore_stb(bank_restore_stb), .target_speed(target_speed),
    .current_speed(current_speed), .analog_detect(analog_detect),
    .digital_func(digital_func), .function_output(function_output),
    .analog_run(analog_run), .format_enables(format_enables),
    .active_address(active_address), .long_addr_sel(long_addr_sel),
    .dir_request(dir_request), .consist_sel(consist_sel),
    .consist_active(consist_active), .direction_reverse(direction_reverse),
    .asymmetric_stop_detect(asymmetric_stop_detect),
    .dc_brake_section(dc_brake_section),
    .dc_section_reverse(dc_section_reverse), .dc_brake_stop(dc_brake_stop),
    .feedback_enables(feedback_enables), .speed_steps_28(speed_steps_28),
    .speed_table_sel(speed_table_sel), .fault_event(fault_event),
    .fault_flags(fault_flags));

  task automatic chk(input string what, input logic [15:0] seen,
    input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [9:0] n, input logic [7:0] d);
    u_station.xfer(1'b1, n, d, ans);
  endtask

  task automatic rd(input logic [9:0] n, input logic [7:0] d,
    input logic r = 1'b0);
    u_station.xfer(1'b0, n, 8'h00, ans);
    chk("read answer", {6'h00, ans}, {6'h00, 1'b1, r, d});
  endtask

  // Decoded outputs follow one edge after the variable changes
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    stop_test();
  end

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 20; i++) begin
      rd(rn[i], rv[i]);
    end
    rd(10'h009, 8'h00);
    chk("active_address", active_address, 16'd3);
    chk("format_enables", format_enables, 16'hF);
    chk("feedback_enables", feedback_enables, 16'h7);
    chk("speed_steps_28", speed_steps_28, 16'h1);
    chk("speed_table_sel", speed_table_sel, 16'h0);
    $display("test reset done");
    wr(10'h005, 8'h3F);
    wr(10'h006, 8'h20);
    rd(10'h005, 8'h3F);
    wr(10'h007, 8'hAA);
    rd(10'h007, FW);
    wr(10'h009, 8'h55);
    rd(10'h009, 8'h00);
    $display("test access done");
    wr(10'h010, 8'h02);
    rd(10'h001, 8'h00, 1'b1);
    wr(10'h001, 8'h44);
    chk("write refused", ans[8], 16'h1);
    wr(10'h005, 8'h11);
    wr(10'h00F, 8'h02);
    rd(10'h001, 8'h03);
    rd(10'h005, 8'h3F);
    $display("test lock done");
    wr(10'h011, 8'hC1);
    wr(10'h012, 8'h2C);
    wr(10'h01D, 8'h2E);
    settle();
    chk("long address", active_address, 16'd300);
    chk("long_addr_sel", long_addr_sel, 16'h1);
    wr(10'h01D, 8'h17);
    settle();
    chk("steps 28", speed_steps_28, 16'h1);
    chk("table", speed_table_sel, 16'h1);
    chk("feedback off", feedback_enables, 16'h4);
    chk("inverted", direction_reverse, 16'h1);
    chk("short address", active_address, 16'd3);
    wr(10'h01D, 8'h08);
    wr(10'h00C, 8'h19);
    settle();
    chk("steps 14", speed_steps_28, 16'h0);
    chk("feedback on", feedback_enables, 16'h7);
    chk("not inverted", direction_reverse, 16'h0);
    chk("formats", format_enables, 16'hD);
    $display("test config done");
    wr(10'h00C, 8'h01);
    wr(10'h01D, 8'h04);
    wr(10'h00D, 8'hA5);
    wr(10'h00E, 8'h91);
    @(posedge clk);
    analog_detect <= 1'b1;
    digital_func <= 13'h0F0F;
    settle();
    chk("analog run", analog_run, 16'h1);
    chk("analog keys", function_output, 16'h134B);
    wr(10'h01D, 8'h00);
    settle();
    chk("digital only", analog_run, 16'h0);
    $display("test analog done");
    wr(10'h013, 8'h85);
    @(posedge clk);
    consist_sel <= 1'b1;
    settle();
    chk("consist on", consist_active, 16'h1);
    chk("consist reverse", direction_reverse, 16'h1);
    wr(10'h013, 8'h00);
    @(posedge clk);
    consist_sel <= 1'b0;
    settle();
    chk("consist off", consist_active, 16'h0);
    $display("test consist done");
    wr(10'h01B, 8'h01);
    settle();
    chk("asym right", asymmetric_stop_detect, 16'h1);
    wr(10'h01B, 8'h82);
    settle();
    chk("asym reverse only", asymmetric_stop_detect, 16'h0);
    @(posedge clk);
    dir_request <= 1'b1;
    settle();
    chk("asym reverse", asymmetric_stop_detect, 16'h1);
    chk("reverse request", direction_reverse, 16'h1);
    wr(10'h01B, 8'h20);
    @(posedge clk);
    dir_request <= 1'b0;
    dc_brake_section <= 1'b1;
    settle();
    chk("dc stop", dc_brake_stop, 16'h1);
    @(posedge clk);
    dc_section_reverse <= 1'b1;
    settle();
    chk("dc no stop", dc_brake_stop, 16'h0);
    $display("test brake done");
    @(posedge clk);
    fault_event <= 3'h2;
    @(posedge clk);
    fault_event <= 3'h0;
    settle();
    chk("motor fault", fault_flags, 16'h2);
    @(posedge clk);
    fault_event <= 3'h5;
    @(posedge clk);
    fault_event <= 3'h0;
    settle();
    chk("all faults", fault_flags, 16'h7);
    wr(10'h01E, 8'h00);
    rd(10'h01E, 8'h00);
    $display("test fault done");
    wr(10'h003, 8'h01);
    @(posedge clk);
    target_speed <= 8'h03;
    cnt = 0;
    while (current_speed !== 8'h03 && cnt < 40) begin
      @(posedge clk);
      cnt++;
    end
    chk("ramp cycles", 16'((cnt >= 8) && (cnt <= 14)), 16'h1);
    // Delay 2 doubles the step interval
    wr(10'h003, 8'h02);
    @(posedge clk);
    target_speed <= 8'h05;
    cnt = 0;
    while (current_speed !== 8'h05 && cnt < 40) begin
      @(posedge clk);
      cnt++;
    end
    chk("slow ramp cycles", 16'((cnt >= 14) && (cnt <= 17)), 16'h1);
    $display("test ramp done");
    wr(10'h008, 8'h03);
    chk("bank restore", {bank_restore_stb, bank_restore}, 16'h5);
    wr(10'h008, 8'h01);
    rd(10'h003, 8'h05);
    rd(10'h005, 8'h30);
    rd(10'h010, 8'h01);
    $display("test restore done");
    stop_test();
  end
endmodule
`default_nettype wire
